// ==== mdm_pkg.sv ====
// Purpose: shared constants and types of the data-move memory path
// Assumes: one clock, registers reached over APB with 32-bit data
// Notes: opcode values are the core's instruction encodings
package mdm_pkg;
    // machine cycle length in clocks
    localparam int MC_CLOCKS = 4;
    localparam int MIN_MC = 2;
    localparam int MAX_MC = 9;
    localparam int ALE_CLOCKS = 2;
    localparam int STR_W = 3;
    localparam int XRAM_AW = 10;
    localparam int SCR_AW = 8;
    localparam logic [15:0] ONCHIP_TOP = 16'h03ff;

    localparam logic [7:0] FREG_BASE = 8'h80;
    localparam logic [7:0] FREG_PTR0_LO = 8'h82;
    localparam logic [7:0] FREG_PTR0_HI = 8'h83;
    localparam logic [7:0] FREG_PTR1_LO = 8'h84;
    localparam logic [7:0] FREG_PTR1_HI = 8'h85;
    localparam logic [7:0] FREG_PSEL = 8'h86;
    localparam logic [7:0] FREG_ABSENT = 8'hff;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PSEL = 8'h04;
    localparam logic [7:0] OFF_PTR0 = 8'h08;
    localparam logic [7:0] OFF_PTR1 = 8'h0c;
    localparam logic [7:0] OFF_CMD = 8'h10;
    localparam logic [7:0] OFF_WDATA = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_PORT = 8'h1c;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_STR_LSB = 1;
    localparam int CTRL_WAIT_BIT = 4;
    localparam int CMD_SADDR_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ONCHIP_BIT = 1;
    localparam int STAT_DATA_LSB = 8;
    localparam int PORT_P2_LSB = 8;
    localparam int PORT_P4_BIT = 16;

    localparam logic [STR_W-1:0] STR_RST = 3'h0;
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam logic [15:0] PTR_RST = 16'h0000;

    typedef enum logic [7:0] {
        OP_XRD = 8'he0,
        OP_XWR = 8'hf0,
        OP_CODE = 8'h93,
        OP_PDEC = 8'ha5,
        OP_DRD = 8'he5,
        OP_IRD = 8'he6,
        OP_DWR = 8'hf5,
        OP_IWR = 8'hf6
    } mdm_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXT = 3'b010,
        ST_INT = 3'b100
    } mdm_state_t;

    typedef struct packed {
        logic [7:0] p0_out;
        logic [7:0] p0_oe;
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
        logic rd_n;
        logic wr_n;
        logic psen_n;
        logic ale;
        logic p40_out;
        logic p40_oe;
    } mdm_pins_t;

    typedef struct packed {
        logic [7:0] p0_in;
        logic p40_in;
    } mdm_pins_in_t;
endpackage : mdm_pkg

// ==== mdm_sync_ram.sv ====
// Purpose: single-port synchronous byte memory
// Assumes: read data registered, one clock after the address
// Notes: contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module mdm_sync_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    if (AW < 1 || AW > 16 || DW < 1) begin : g_bad_size
        $error("ram size not supported");
    end

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : mdm_sync_ram
`default_nettype wire

// ==== mdm_cycle_timer.sv ====
// Purpose: paces one external bus cycle in clocks
// Assumes: hold is already qualified by the wait enable
// Notes: length is latched at start, so a stretch change waits
`timescale 1ns/1ps
`default_nettype none
module mdm_cycle_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [mdm_pkg::STR_W-1:0] stretch,
    input wire logic hold,
    output logic busy,
    output logic ale,
    output logic strobe,
    output logic sample,
    output logic done
);
    if (mdm_pkg::MIN_MC + 2**mdm_pkg::STR_W - 1 != mdm_pkg::MAX_MC)
    begin : g_bad_stretch
        $error("stretch field does not span the cycle range");
    end

    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [5:0] last;
    } mdm_tmr_t;

    mdm_tmr_t r_reg;
    mdm_tmr_t r_next;

    function automatic logic [5:0] cycle_clocks(
        input logic [mdm_pkg::STR_W-1:0] s);
        cycle_clocks = 6'((mdm_pkg::MIN_MC + int'(s)) *
                          mdm_pkg::MC_CLOCKS);
    endfunction : cycle_clocks

    always_comb begin
        r_next = r_reg;
        if (!r_reg.busy) begin
            if (start) begin
                r_next.busy = 1'b1;
                r_next.cnt = 6'h00;
                r_next.last = cycle_clocks(stretch) - 6'h01;
            end
        end else if (r_reg.cnt == r_reg.last) begin
            r_next.busy = 1'b0;
        end else if (!(hold && r_reg.cnt == r_reg.last - 6'h01)) begin
            r_next.cnt = r_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign busy = r_reg.busy;
    assign ale = r_reg.busy && r_reg.cnt < 6'(mdm_pkg::ALE_CLOCKS);
    assign strobe = r_reg.busy && r_reg.last != r_reg.cnt &&
                    r_reg.cnt >= 6'(mdm_pkg::MC_CLOCKS);
    assign sample = strobe && !hold && r_reg.cnt == r_reg.last - 6'h01;
    assign done = r_reg.busy && r_reg.cnt == r_reg.last;

    a_min_length: assert property (@(posedge pclk) disable iff (!presetn)
        start && !busy |=> busy [*8])
        else $error("bus cycle shorter than two machine cycles");

    a_max_length: assert property (@(posedge pclk) disable iff (!presetn)
        start && !busy && stretch == 3'h7 |=> busy [*8] ##29 !busy)
        else $error("longest bus cycle not nine machine cycles");
endmodule : mdm_cycle_timer
`default_nettype wire

// ==== mdm_data_path.sv ====
// Purpose: routes data moves to on-chip sram, scratchpad or the bus
// Assumes: APB slave, zero wait states, pins synchronous to pclk
// Notes: commands are refused while an access is in flight
`timescale 1ns/1ps
`default_nettype none
module mdm_data_path (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mdm_pkg::mdm_pins_in_t pins_in,
    output mdm_pkg::mdm_pins_t pins
);
    typedef struct packed {
        mdm_pkg::mdm_state_t st;
        logic en;
        logic [mdm_pkg::STR_W-1:0] stretch;
        logic wait_en;
        logic ptr_sel;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0] p0l;
        logic [7:0] p2l;
        logic p4l;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [7:0] op;
        logic [15:0] addr;
        logic [7:0] saddr;
        logic onchip;
        logic [1:0] cnt;
        logic [31:0] prdata;
        logic pslverr;
    } mdm_top_t;

    mdm_top_t r_reg;
    mdm_top_t r_next;

    logic wr;
    logic cmd_go;
    logic ext;
    logic ext_start;
    logic hold;
    logic t_ale;
    logic t_strobe;
    logic t_sample;
    logic t_done;
    logic xram_we;
    logic scr_we;
    logic [7:0] xram_q;
    logic [7:0] scr_q;
    logic [7:0] cmd_op;
    logic [7:0] cmd_saddr;

    function automatic logic [15:0] act_ptr(input mdm_top_t s);
        act_ptr = s.ptr_sel ? s.ptr1 : s.ptr0;
    endfunction : act_ptr

    function automatic logic hits_onchip(input mdm_top_t s);
        hits_onchip = s.en && act_ptr(s) <= mdm_pkg::ONCHIP_TOP;
    endfunction : hits_onchip

    function automatic logic is_read(input logic [7:0] op);
        is_read = op == mdm_pkg::OP_XRD || op == mdm_pkg::OP_CODE ||
                  op == mdm_pkg::OP_DRD || op == mdm_pkg::OP_IRD;
    endfunction : is_read

    function automatic logic is_scr_wr(input logic [7:0] op);
        is_scr_wr = op == mdm_pkg::OP_DWR || op == mdm_pkg::OP_IWR;
    endfunction : is_scr_wr

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            mdm_pkg::OFF_CTRL, mdm_pkg::OFF_PSEL, mdm_pkg::OFF_PTR0,
            mdm_pkg::OFF_PTR1, mdm_pkg::OFF_CMD, mdm_pkg::OFF_WDATA,
            mdm_pkg::OFF_STAT, mdm_pkg::OFF_PORT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // unimplemented function registers read high
    function automatic logic [7:0] freg_read(input mdm_top_t s,
                                             input logic [7:0] a);
        case (a)
            mdm_pkg::FREG_PTR0_LO: freg_read = s.ptr0[7:0];
            mdm_pkg::FREG_PTR0_HI: freg_read = s.ptr0[15:8];
            mdm_pkg::FREG_PTR1_LO: freg_read = s.ptr1[7:0];
            mdm_pkg::FREG_PTR1_HI: freg_read = s.ptr1[15:8];
            mdm_pkg::FREG_PSEL: freg_read = {7'h00, s.ptr_sel};
            default: freg_read = mdm_pkg::FREG_ABSENT;
        endcase
    endfunction : freg_read

    function automatic logic [31:0] read_mux(input mdm_top_t s,
                                             input logic [7:0] a);
        read_mux = 32'h00000000;
        case (a)
            mdm_pkg::OFF_CTRL: begin
                read_mux[mdm_pkg::CTRL_EN_BIT] = s.en;
                read_mux[mdm_pkg::CTRL_STR_LSB +: mdm_pkg::STR_W] =
                    s.stretch;
                read_mux[mdm_pkg::CTRL_WAIT_BIT] = s.wait_en;
            end
            mdm_pkg::OFF_PSEL: read_mux[0] = s.ptr_sel;
            mdm_pkg::OFF_PTR0: read_mux[15:0] = s.ptr0;
            mdm_pkg::OFF_PTR1: read_mux[15:0] = s.ptr1;
            mdm_pkg::OFF_WDATA: read_mux[7:0] = s.wdata;
            mdm_pkg::OFF_STAT: begin
                read_mux[mdm_pkg::STAT_BUSY_BIT] =
                    s.st != mdm_pkg::ST_IDLE;
                read_mux[mdm_pkg::STAT_ONCHIP_BIT] = s.onchip;
                read_mux[mdm_pkg::STAT_DATA_LSB +: 8] = s.rdata;
            end
            mdm_pkg::OFF_PORT: begin
                read_mux[7:0] = s.p0l;
                read_mux[mdm_pkg::PORT_P2_LSB +: 8] = s.p2l;
                read_mux[mdm_pkg::PORT_P4_BIT] = s.p4l;
            end
            default: read_mux = 32'h00000000;
        endcase
    endfunction : read_mux

    assign wr = psel && penable && pwrite;
    assign cmd_go = wr && paddr == mdm_pkg::OFF_CMD &&
                    r_reg.st == mdm_pkg::ST_IDLE;
    assign cmd_op = pwdata[7:0];
    assign cmd_saddr = pwdata[mdm_pkg::CMD_SADDR_LSB +: 8];
    assign ext = r_reg.st == mdm_pkg::ST_EXT;
    // wait pin is active low
    assign hold = r_reg.wait_en && !pins_in.p40_in;

    always_comb begin
        r_next = r_reg;
        ext_start = 1'b0;
        if (psel && !penable) begin
            r_next.prdata = pwrite ? 32'h00000000 : read_mux(r_reg, paddr);
            r_next.pslverr = !is_mapped(paddr);
        end
        if (wr) begin
            case (paddr)
                mdm_pkg::OFF_CTRL: begin
                    r_next.en = pwdata[mdm_pkg::CTRL_EN_BIT];
                    r_next.stretch =
                        pwdata[mdm_pkg::CTRL_STR_LSB +: mdm_pkg::STR_W];
                    r_next.wait_en = pwdata[mdm_pkg::CTRL_WAIT_BIT];
                end
                mdm_pkg::OFF_PSEL: r_next.ptr_sel = pwdata[0];
                mdm_pkg::OFF_PTR0: r_next.ptr0 = pwdata[15:0];
                mdm_pkg::OFF_PTR1: r_next.ptr1 = pwdata[15:0];
                mdm_pkg::OFF_WDATA: r_next.wdata = pwdata[7:0];
                mdm_pkg::OFF_PORT: begin
                    r_next.p0l = pwdata[7:0];
                    r_next.p2l = pwdata[mdm_pkg::PORT_P2_LSB +: 8];
                    r_next.p4l = pwdata[mdm_pkg::PORT_P4_BIT];
                end
                default: ;
            endcase
        end
        case (r_reg.st)
            mdm_pkg::ST_IDLE: begin
                if (cmd_go) begin
                    r_next.op = cmd_op;
                    r_next.saddr = cmd_saddr;
                    r_next.addr = act_ptr(r_reg);
                    r_next.cnt = 2'h0;
                    case (cmd_op)
                        mdm_pkg::OP_XRD, mdm_pkg::OP_XWR: begin
                            if (hits_onchip(r_reg)) begin
                                r_next.st = mdm_pkg::ST_INT;
                                r_next.onchip = 1'b1;
                            end else begin
                                r_next.st = mdm_pkg::ST_EXT;
                                r_next.onchip = 1'b0;
                                ext_start = 1'b1;
                            end
                        end
                        mdm_pkg::OP_CODE: begin
                            // program space is always off-chip
                            r_next.st = mdm_pkg::ST_EXT;
                            r_next.onchip = 1'b0;
                            ext_start = 1'b1;
                        end
                        mdm_pkg::OP_PDEC: begin
                            if (r_reg.ptr_sel) begin
                                r_next.ptr1 = r_reg.ptr1 - 16'h0001;
                            end else begin
                                r_next.ptr0 = r_reg.ptr0 - 16'h0001;
                            end
                        end
                        mdm_pkg::OP_DRD, mdm_pkg::OP_DWR: begin
                            r_next.onchip = 1'b0;
                            if (cmd_saddr >= mdm_pkg::FREG_BASE) begin
                                // direct upper half reaches function regs
                                if (cmd_op == mdm_pkg::OP_DRD) begin
                                    r_next.rdata =
                                        freg_read(r_reg, cmd_saddr);
                                end else begin
                                    case (cmd_saddr)
                                        mdm_pkg::FREG_PTR0_LO:
                                            r_next.ptr0[7:0] = r_reg.wdata;
                                        mdm_pkg::FREG_PTR0_HI:
                                            r_next.ptr0[15:8] = r_reg.wdata;
                                        mdm_pkg::FREG_PTR1_LO:
                                            r_next.ptr1[7:0] = r_reg.wdata;
                                        mdm_pkg::FREG_PTR1_HI:
                                            r_next.ptr1[15:8] = r_reg.wdata;
                                        mdm_pkg::FREG_PSEL:
                                            r_next.ptr_sel = r_reg.wdata[0];
                                        default: ;
                                    endcase
                                end
                            end else begin
                                r_next.st = mdm_pkg::ST_INT;
                            end
                        end
                        mdm_pkg::OP_IRD, mdm_pkg::OP_IWR: begin
                            r_next.onchip = 1'b0;
                            r_next.st = mdm_pkg::ST_INT;
                        end
                        default: ;
                    endcase
                end
            end
            mdm_pkg::ST_INT: begin
                r_next.cnt = r_reg.cnt + 2'h1;
                if (r_reg.cnt == 2'(mdm_pkg::MC_CLOCKS - 1)) begin
                    r_next.st = mdm_pkg::ST_IDLE;
                    if (is_read(r_reg.op)) begin
                        r_next.rdata = r_reg.onchip ? xram_q : scr_q;
                    end
                end
            end
            mdm_pkg::ST_EXT: begin
                if (t_sample && is_read(r_reg.op)) begin
                    r_next.rdata = pins_in.p0_in;
                end
                if (t_done) begin
                    r_next.st = mdm_pkg::ST_IDLE;
                end
            end
            default: r_next.st = mdm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.st <= mdm_pkg::ST_IDLE;
            r_reg.en <= 1'b0;
            r_reg.stretch <= mdm_pkg::STR_RST;
            r_reg.ptr0 <= mdm_pkg::PTR_RST;
            r_reg.ptr1 <= mdm_pkg::PTR_RST;
            r_reg.p0l <= mdm_pkg::PORT_RST;
            r_reg.p2l <= mdm_pkg::PORT_RST;
            r_reg.p4l <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // memory writes land in the first clock of the on-chip cycle
    assign xram_we = r_reg.st == mdm_pkg::ST_INT && r_reg.cnt == 2'h0 &&
                     r_reg.onchip && r_reg.op == mdm_pkg::OP_XWR;
    assign scr_we = r_reg.st == mdm_pkg::ST_INT && r_reg.cnt == 2'h0 &&
                    !r_reg.onchip && is_scr_wr(r_reg.op);

    mdm_sync_ram #(
        .AW(mdm_pkg::XRAM_AW),
        .DW(8)
    ) u_xram (
        .pclk(pclk),
        .we(xram_we),
        .addr(r_reg.addr[mdm_pkg::XRAM_AW-1:0]),
        .wdata(r_reg.wdata),
        .rdata(xram_q)
    );

    mdm_sync_ram #(
        .AW(mdm_pkg::SCR_AW),
        .DW(8)
    ) u_scratch (
        .pclk(pclk),
        .we(scr_we),
        .addr(r_reg.saddr),
        .wdata(r_reg.wdata),
        .rdata(scr_q)
    );

    mdm_cycle_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(ext_start),
        .stretch(r_reg.stretch),
        .hold(hold),
        .busy(),
        .ale(t_ale),
        .strobe(t_strobe),
        .sample(t_sample),
        .done(t_done)
    );

    assign prdata = r_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = r_reg.pslverr;

    // outside bus cycles port 0 is open drain: only zeros are driven
    always_comb begin
        pins.p0_out = 8'h00;
        pins.p0_oe = ~r_reg.p0l;
        if (ext) begin
            pins.p0_out = t_ale ? r_reg.addr[7:0] : r_reg.wdata;
            pins.p0_oe = (t_ale || r_reg.op == mdm_pkg::OP_XWR) ?
                         8'hff : 8'h00;
        end
        pins.p2_out = ext ? r_reg.addr[15:8] : r_reg.p2l;
        pins.p2_oe = 8'hff;
        pins.rd_n = !(ext && t_strobe && r_reg.op == mdm_pkg::OP_XRD);
        pins.wr_n = !(ext && t_strobe && r_reg.op == mdm_pkg::OP_XWR);
        pins.psen_n = !(ext && t_strobe && r_reg.op == mdm_pkg::OP_CODE);
        pins.ale = ext && t_ale;
        pins.p40_out = 1'b0;
        pins.p40_oe = !r_reg.wait_en && !r_reg.p4l;
    end

    a_reset_sram_off: assert property (@(posedge pclk)
        disable iff (!presetn) !$past(presetn) |-> !r_reg.en)
        else $error("sram enabled right after reset");

    a_low_goes_int: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && cmd_op == mdm_pkg::OP_XRD &&
        r_reg.en && act_ptr(r_reg) <= 16'h03ff
        |=> r_reg.st == mdm_pkg::ST_INT && r_reg.onchip)
        else $error("enabled low address not served on chip");

    a_high_goes_ext: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && cmd_op == mdm_pkg::OP_XWR &&
        act_ptr(r_reg) > 16'h03ff |=> ext ##[1:8] !pins.wr_n)
        else $error("high address did not reach the bus");

    a_off_goes_ext: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && !r_reg.en &&
        cmd_op == mdm_pkg::OP_XRD |=> ext && !r_reg.onchip)
        else $error("disabled sram still served an access");

    a_code_external: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && cmd_op == mdm_pkg::OP_CODE
        |=> ext ##[4:8] !pins.psen_n)
        else $error("code read not issued on the bus");

    a_onchip_quiet: assert property (@(posedge pclk)
        disable iff (!presetn) r_reg.st == mdm_pkg::ST_INT
        |-> pins.rd_n && pins.wr_n && !pins.ale &&
            pins.p2_out == r_reg.p2l)
        else $error("bus pins moved during on-chip access");

    a_ptr_select: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && cmd_op == mdm_pkg::OP_XRD
        |=> r_reg.addr == ($past(r_reg.ptr_sel) ? $past(r_reg.ptr1) :
                           $past(r_reg.ptr0)))
        else $error("access used the wrong pointer");

    a_ptr_decrement: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && cmd_op == mdm_pkg::OP_PDEC &&
        !r_reg.ptr_sel |=> r_reg.ptr0 == $past(r_reg.ptr0) - 16'h0001)
        else $error("pointer decrement wrong");

    a_freg_direct: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_go && cmd_op == mdm_pkg::OP_DRD &&
        cmd_saddr >= 8'h80 |=> r_reg.st == mdm_pkg::ST_IDLE)
        else $error("direct register read touched the scratchpad");

    a_port_drive: assert property (@(posedge pclk)
        disable iff (!presetn) pins.ale |-> pins.p0_oe == 8'hff &&
        pins.p2_out == r_reg.addr[15:8])
        else $error("address not driven on ports 0 and 2");

    a_wait_input: assert property (@(posedge pclk)
        disable iff (!presetn) r_reg.wait_en |-> !pins.p40_oe)
        else $error("wait pin driven while enabled");
endmodule : mdm_data_path
`default_nettype wire

// ==== mdm_ext_mem.sv ====
// Purpose: external data memory on the multiplexed bus
// Assumes: ale, rd_n, wr_n and psen_n from the data path, 256 byte image
// Notes: released bus shows inverse of last value, not a hold
`timescale 1ns/1ps
`default_nettype none
module mdm_ext_mem (
    input wire logic pclk,
    input wire mdm_pkg::mdm_pins_t pins,
    output mdm_pkg::mdm_pins_in_t pins_in
);
    logic [7:0] mem [0:255];
    logic [15:0] addr_reg;
    logic [7:0] last_reg = 8'h00;
    always_ff @(posedge pclk) begin
        if (pins.ale) begin
            addr_reg <= {pins.p2_out, pins.p0_out};
        end
        if (!pins.wr_n) begin
            mem[addr_reg[7:0]] <= pins.p0_out;
        end
        if (!pins.rd_n) begin
            last_reg <= mem[addr_reg[7:0]];
        end
    end
    // answers at once, well inside even the shortest window
    // code image byte is the inverted low address: cheap, predictable
    assign pins_in.p0_in = !pins.rd_n ? mem[addr_reg[7:0]] :
                           !pins.psen_n ? ~addr_reg[7:0] : ~last_reg;
    assign pins_in.p40_in = 1'b1;
endmodule : mdm_ext_mem
`default_nettype wire

// ==== tb_external_data_move_data_memory_map.sv ====
// Purpose: register level tests of the data-move memory path
// Assumes: zero wait APB slave, busy polled after each command
// Notes: external image is looked at through the partner model
`timescale 1ns/1ps
`default_nettype none
module tb_external_data_move_data_memory_map;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mdm_pkg::mdm_pins_t pins;
    mdm_pkg::mdm_pins_in_t pins_in;
    int err_total = 0;
    int check_count = 0;
    mdm_data_path i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_in(pins_in), .pins(pins));
    mdm_ext_mem i_mem (.pclk(pclk), .pins(pins), .pins_in(pins_in));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] e, s);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rc
    task automatic cmd(input logic [15:0] c);
        logic [31:0] q;
        wr(mdm_pkg::OFF_CMD, {16'h0, c});
        do apb(1'b0, mdm_pkg::OFF_STAT, 32'h0, q); while (q[0] !== 1'b0);
    endtask : cmd
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rc(mdm_pkg::OFF_CTRL, 32'h0);
        $display("reset test done");
        wr(mdm_pkg::OFF_WDATA, 32'h5a);
        wr(mdm_pkg::OFF_PTR0, 32'h0010);
        cmd(16'hf0);
        chk("ext 0010", 32'h5a, {24'h0, i_mem.mem[8'h10]});
        cmd(16'he0);
        rc(mdm_pkg::OFF_STAT, 32'h5a00);
        $display("disabled test done");
        wr(mdm_pkg::OFF_CTRL, 32'h1);
        wr(mdm_pkg::OFF_WDATA, 32'hc3);
        cmd(16'hf0);
        chk("ext kept", 32'h5a, {24'h0, i_mem.mem[8'h10]});
        wr(mdm_pkg::OFF_WDATA, 32'h3c);
        cmd(16'h10f6);
        cmd(16'h10e6);
        rc(mdm_pkg::OFF_STAT, 32'h3c00);
        cmd(16'he0);
        rc(mdm_pkg::OFF_STAT, 32'hc302);
        cmd(16'h93);
        rc(mdm_pkg::OFF_STAT, 32'hef00);
        $display("on-chip test done");
        // longest stretch, wait enabled but the far side never holds
        wr(mdm_pkg::OFF_CTRL, 32'h1f);
        wr(mdm_pkg::OFF_PTR0, 32'h0420);
        wr(mdm_pkg::OFF_WDATA, 32'h77);
        cmd(16'hf0);
        chk("ext 0420", 32'h77, {24'h0, i_mem.mem[8'h20]});
        $display("above test done");
        wr(mdm_pkg::OFF_PSEL, 32'h1);
        wr(mdm_pkg::OFF_PTR1, 32'h0);
        cmd(16'ha5);
        rc(mdm_pkg::OFF_PTR1, 32'hffff);
        rc(mdm_pkg::OFF_PTR0, 32'h0420);
        wr(mdm_pkg::OFF_PSEL, 32'h0);
        cmd(16'ha5);
        rc(mdm_pkg::OFF_PTR0, 32'h041f);
        cmd(16'h83e5);
        rc(mdm_pkg::OFF_STAT, 32'h0400);
        $display("pointer test done");
        rc(8'h20, 32'h0);
        chk("pslverr", 32'h1, {31'h0, pslverr});
        $display("bus error test done");
        test_done;
    end
endmodule : tb_external_data_move_data_memory_map
`default_nettype wire
